// *** hw/gtm_defines.svh ***
// offsets, field positions, reset values and codes for the 16-bit timer half
`ifndef GTM_DEFINES_SVH
`define GTM_DEFINES_SVH

`define GTM_ADDR_W 4
`define GTM_OFS_CONFIG 4'h0
`define GTM_OFS_MODE 4'h1
`define GTM_OFS_CTRL 4'h2
`define GTM_OFS_LOAD 4'h3
`define GTM_OFS_MATCH 4'h4
`define GTM_OFS_PRESCALE 4'h5
`define GTM_OFS_VALUE 4'h6
`define GTM_OFS_RAW 4'h7
`define GTM_OFS_MASK 4'h8
`define GTM_OFS_MASKED 4'h9
`define GTM_OFS_CLEAR 4'hA
`define GTM_OFS_COUNT 4'hB

`define GTM_CFG_16BIT 3'h4
`define GTM_TMR_ONESHOT 2'h1
`define GTM_TMR_PERIODIC 2'h2
`define GTM_TMR_CAPTURE 2'h3

// mode register: [1:0] mode field, [2] capture select, [3] alternate
`define GTM_MODE_CMR 2
`define GTM_MODE_AMS 3
// control register bits
`define GTM_CTL_EN 0
`define GTM_CTL_STALL 1
`define GTM_CTL_EVT_LO 2
`define GTM_CTL_EVT_HI 3
`define GTM_CTL_OTE 5
`define GTM_CTL_PWML 6
// status bits: timeout, count match, edge event
`define GTM_IRQ_TO 0
`define GTM_IRQ_CM 1
`define GTM_IRQ_CE 2

`define GTM_EVT_RISE 2'h0
`define GTM_EVT_FALL 2'h1
`define GTM_EVT_BOTH 2'h3

`define GTM_RST_LOAD 16'hFFFF
`define GTM_RST_COUNT 16'hFFFF
`define GTM_RST_PRESCALE 8'h00

`endif

// *** hw/gtm_pkg.sv ***
// types for the 16-bit timer half
package gtm_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gtm_bus_req_t;

  typedef struct packed {
    logic [2:0] config_selector;
    logic [3:0] timer_mode_register;
    logic [6:0] control_register;
    logic [15:0] interval_load_value;
    logic [15:0] match_value;
    logic [7:0] prescale_value;
    logic [15:0] captured_value_register;
    logic [2:0] raw_irq_status;
    logic [2:0] irq_mask_register;
    logic [15:0] count;
    logic [7:0] pre_count;
    logic reload_pend;
    logic [1:0] pin_sync;
    logic pin_prev;
    logic pwm_level;
    logic pwm_out;
    logic trigger;
    logic irq;
    logic [31:0] rdata;
  } gtm_state_t;
endpackage

// *** hw/gtm_timer16.sv ***
// one 16-bit timer half: one-shot, periodic, edge count, edge time, pwm
//
// Our own choices: the strobed register port and the placing of the registers.
`include "gtm_defines.svh"

module gtm_timer16 (
  input wire logic clk,
  input wire logic rst_b,
  input wire gtm_pkg::gtm_bus_req_t bus,
  output logic [31:0] rdata,
  input wire logic capture_compare_pin,
  output logic pwm_out,
  output logic trigger_out,
  output logic irq
);
  import gtm_pkg::*;

  typedef enum logic [5:0] {
    GTM_M_OFF = 6'b000001,
    GTM_M_ONESHOT = 6'b000010,
    GTM_M_PERIODIC = 6'b000100,
    GTM_M_ECOUNT = 6'b001000,
    GTM_M_ETIME = 6'b010000,
    GTM_M_PWM = 6'b100000
  } gtm_mode_t;

  gtm_state_t q, d;
  gtm_mode_t mode;

  // decode of the operating mode from config and mode register
  function automatic gtm_mode_t decode_mode(input logic [2:0] cfg,
                                            input logic [3:0] mr);
    if (cfg != `GTM_CFG_16BIT)
      decode_mode = GTM_M_OFF;
    else if (mr[`GTM_MODE_AMS] && !mr[`GTM_MODE_CMR] &&
             mr[1:0] == `GTM_TMR_PERIODIC)
      decode_mode = GTM_M_PWM;
    else if (mr[1:0] == `GTM_TMR_ONESHOT)
      decode_mode = GTM_M_ONESHOT;
    else if (mr[1:0] == `GTM_TMR_PERIODIC)
      decode_mode = GTM_M_PERIODIC;
    else if (mr[1:0] == `GTM_TMR_CAPTURE && !mr[`GTM_MODE_CMR])
      decode_mode = GTM_M_ECOUNT;
    else if (mr[1:0] == `GTM_TMR_CAPTURE)
      decode_mode = GTM_M_ETIME;
    else
      decode_mode = GTM_M_OFF;
  endfunction

  // edge qualification against the event field
  function automatic logic edge_hit(input logic [1:0] evt,
                                    input logic rise,
                                    input logic fall,
                                    input logic both_ok);
    unique case (evt)
      `GTM_EVT_RISE: edge_hit = rise;
      `GTM_EVT_FALL: edge_hit = fall;
      `GTM_EVT_BOTH: edge_hit = both_ok ? (rise | fall) : rise;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  logic en, stall, rise, fall, hit;
  logic [1:0] evt;

  always_comb begin
    d = q;
    mode = decode_mode(q.config_selector, q.timer_mode_register);
    en = q.control_register[`GTM_CTL_EN];
    stall = q.control_register[`GTM_CTL_STALL];
    evt = q.control_register[`GTM_CTL_EVT_HI:`GTM_CTL_EVT_LO];
    d.trigger = 1'b0;
    d.rdata = 32'h0000_0000;

    // pin synchroniser; only the second stage feeds edge detection
    d.pin_sync = {q.pin_sync[0], capture_compare_pin};
    d.pin_prev = q.pin_sync[1];
    rise = q.pin_sync[1] & ~q.pin_prev;
    fall = ~q.pin_sync[1] & q.pin_prev;
    hit = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // counting
    if (q.reload_pend) begin
      d.reload_pend = 1'b0;
      d.count = q.interval_load_value;
      d.pre_count = q.prescale_value;
    end else if (en && !stall) begin
      unique case (mode)
        GTM_M_ONESHOT, GTM_M_PERIODIC: begin
          if (q.pre_count != 8'h00) begin
            d.pre_count = q.pre_count - 8'h01;
          end else if (q.count == 16'h0000) begin
            d.reload_pend = 1'b1;
            d.raw_irq_status[`GTM_IRQ_TO] = 1'b1;
            d.trigger = q.control_register[`GTM_CTL_OTE];
            if (mode == GTM_M_ONESHOT)
              d.control_register[`GTM_CTL_EN] = 1'b0;
          end else begin
            d.count = q.count - 16'h0001;
            d.pre_count = q.prescale_value;
          end
        end
        GTM_M_ECOUNT: begin
          hit = edge_hit(evt, rise, fall, 1'b1);
          if (hit) begin
            if (q.count - 16'h0001 == q.match_value) begin
              d.count = q.interval_load_value;
              d.raw_irq_status[`GTM_IRQ_CM] = 1'b1;
              d.control_register[`GTM_CTL_EN] = 1'b0;
            end else begin
              d.count = q.count - 16'h0001;
            end
          end
        end
        GTM_M_ETIME: begin
          hit = edge_hit(evt, rise, fall, 1'b0);
          if (hit) begin
            d.captured_value_register = q.count;
            d.raw_irq_status[`GTM_IRQ_CE] = 1'b1;
          end
          if (q.count == 16'h0000)
            d.count = q.interval_load_value;
          else
            d.count = q.count - 16'h0001;
        end
        GTM_M_PWM: begin
          if (q.count == 16'h0000)
            d.reload_pend = 1'b1;
          else
            d.count = q.count - 16'h0001;
          if (q.count == q.interval_load_value)
            d.pwm_level = 1'b1;
          else if (q.count == q.match_value)
            d.pwm_level = 1'b0;
        end
        default: ;
      endcase
    end
    if (!en)
      d.pwm_level = 1'b0;
    d.pwm_out = d.pwm_level ^ q.control_register[`GTM_CTL_PWML];

    ////////////////////////////////////////////////////////////////////////
    // register access
    if (bus.wr) begin
      unique case (bus.addr)
        `GTM_OFS_CONFIG: d.config_selector = bus.wdata[2:0];
        `GTM_OFS_MODE: d.timer_mode_register = bus.wdata[3:0];
        `GTM_OFS_CTRL: begin
          d.control_register = bus.wdata[6:0];
          if (bus.wdata[`GTM_CTL_EN] && !en && mode != GTM_M_ECOUNT) begin
            d.count = q.interval_load_value;
            d.pre_count = q.prescale_value;
          end
        end
        `GTM_OFS_LOAD: begin
          d.interval_load_value = bus.wdata[15:0];
          d.count = bus.wdata[15:0];
          d.reload_pend = 1'b0;
        end
        `GTM_OFS_MATCH: d.match_value = bus.wdata[15:0];
        `GTM_OFS_PRESCALE: d.prescale_value = bus.wdata[7:0];
        `GTM_OFS_MASK: d.irq_mask_register = bus.wdata[2:0];
        // write one to clear; a same-cycle event still sets a bit that was clear
        `GTM_OFS_CLEAR: d.raw_irq_status = d.raw_irq_status &
            ~(bus.wdata[2:0] & ~(d.raw_irq_status & ~q.raw_irq_status));
        default: ;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        `GTM_OFS_CONFIG: d.rdata = {29'h0, q.config_selector};
        `GTM_OFS_MODE: d.rdata = {28'h0, q.timer_mode_register};
        `GTM_OFS_CTRL: d.rdata = {25'h0, q.control_register};
        `GTM_OFS_LOAD: d.rdata = {16'h0, q.interval_load_value};
        `GTM_OFS_MATCH: d.rdata = {16'h0, q.match_value};
        `GTM_OFS_PRESCALE: d.rdata = {24'h0, q.prescale_value};
        `GTM_OFS_VALUE: d.rdata = {16'h0, q.captured_value_register};
        `GTM_OFS_RAW: d.rdata = {29'h0, q.raw_irq_status};
        `GTM_OFS_MASK: d.rdata = {29'h0, q.irq_mask_register};
        `GTM_OFS_MASKED:
          d.rdata = {29'h0, q.raw_irq_status & q.irq_mask_register};
        `GTM_OFS_COUNT: d.rdata = {16'h0, q.count};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    d.irq = |(d.raw_irq_status & d.irq_mask_register);
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.interval_load_value <= `GTM_RST_LOAD;
      q.count <= `GTM_RST_COUNT;
      q.prescale_value <= `GTM_RST_PRESCALE;
      q.pre_count <= `GTM_RST_PRESCALE;
      q.captured_value_register <= `GTM_RST_COUNT;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign pwm_out = q.pwm_out;
  assign trigger_out = q.trigger;
  assign irq = q.irq;
endmodule

// *** tb/gtm_timer16_sva.sv ***
// port checker for the 16-bit timer half
module gtm_timer16_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire gtm_pkg::gtm_bus_req_t bus,
  input wire logic [31:0] rdata,
  input wire logic capture_compare_pin,
  input wire logic pwm_out,
  input wire logic trigger_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import gtm_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // shadow of software writes
  logic [2:0] cfg_q;
  logic [2:0] msk_q;
  logic ote_q;
  logic [15:0] load_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= 3'h0;
      msk_q <= 3'h0;
      ote_q <= 1'b0;
      load_q <= 16'hFFFF;
    end else if (bus.wr) begin
      if (bus.addr == 4'h0) cfg_q <= bus.wdata[2:0];
      if (bus.addr == 4'h8) msk_q <= bus.wdata[2:0];
      if (bus.addr == 4'h2) ote_q <= bus.wdata[5];
      if (bus.addr == 4'h3) load_q <= bus.wdata[15:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data not idle");
  hi_zero_a: assert property ($past(bus.rd) |-> rdata[31:16] == 16'h0)
    else $error("upper read bits set");
  trig_pulse_a: assert property (trigger_out |=> !trigger_out)
    else $error("trigger longer than one cycle");
  trig_en_a: assert property (trigger_out |-> ote_q || $past(ote_q))
    else $error("trigger while disabled");
  cfg_gate_a: assert property (trigger_out |->
    cfg_q == 3'h4 || $past(cfg_q) == 3'h4)
    else $error("trigger outside 16-bit config");
  irq_mask_a: assert property (irq |-> msk_q != 0 || $past(msk_q) != 0)
    else $error("interrupt while all masked");
  cfg_back_a: assert property ($past(bus.rd && bus.addr == 4'h0) |->
    rdata[2:0] == $past(cfg_q))
    else $error("config readback wrong");
  load_back_a: assert property ($past(bus.rd && bus.addr == 4'h3) |->
    rdata[15:0] == $past(load_q))
    else $error("load readback wrong");
endmodule
bind gtm_timer16 gtm_timer16_sva u_sva (
  .clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
  .capture_compare_pin(capture_compare_pin), .pwm_out(pwm_out),
  .trigger_out(trigger_out), .irq(irq)
);

// *** tb/gtm_pin_model.sv ***
// capture pin source: each level held five clocks
module gtm_pin_model (
  input wire logic clk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b0;
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge clk);
      pin <= ~pin;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// *** tb/tb_top.sv ***
// register-level tests of the 16-bit timer half
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gtm_pkg::*;
  logic clk = 1'b0;
  logic rst_b;
  gtm_pkg::gtm_bus_req_t bus;
  logic [31:0] rdata;
  logic [31:0] v;
  logic pin, pwm, trig, irq;
  int miscompares = 0;
  int samples_checked = 0;
  int n, hi;
  logic [1:0] evs [3] = '{2'h3, 2'h0, 2'h1};
  logic [15:0] cnt [3] = '{16'hA, 16'h7, 16'h8};
  logic mt [3] = '{1'b1, 1'b0, 1'b0};
  always #4 clk = ~clk;
  gtm_timer16 DUT (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .capture_compare_pin(pin), .pwm_out(pwm), .trigger_out(trig),
    .irq(irq));
  gtm_pin_model u_pin (.clk(clk), .pin(pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    chk(q, e);
  endtask
  task automatic wait_trig(input int lim, output int c);
    c = 0;
    while (trig !== 1'b1 && c < lim) begin
      @(posedge clk);
      #1 c++;
    end
  endtask
  task automatic duty(output int h);
    h = 0;
    repeat (180) begin
      @(posedge clk);
      #1 h += int'(pwm === 1'b1);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    rst_b = 1'b0;
    bus = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rc(4'h3, 32'hFFFF);
    rc(4'hB, 32'hFFFF);
    rc(4'h5, 32'h0);
    rc(4'hF, 32'h0);
    wr(4'h0, 32'h4);
    wr(4'hF, 32'h7);
    rc(4'h0, 32'h4);
    // one-shot, trigger off, all masked
    wr(4'h1, 32'h1);
    wr(4'h3, 32'h8);
    wr(4'h2, 32'h1);
    wait_trig(40, n);
    chk(n, 40);
    rc(4'h2, 32'h0);
    rc(4'hB, 32'h8);
    rc(4'h7, 32'h1);
    chk(irq, 0);
    // periodic with prescaler and trigger
    wr(4'hA, 32'h7);
    wr(4'h8, 32'h1);
    wr(4'h1, 32'h2);
    wr(4'h5, 32'h1);
    wr(4'h3, 32'h10);
    wr(4'h2, 32'h21);
    wait_trig(80, n);
    chk(n < 80, 1);
    rd(4'hB, v);
    rc(4'hB, v - 1);
    rc(4'h2, 32'h21);
    chk(irq, 1);
    rc(4'h9, 32'h1);
    wr(4'h2, 32'h23);
    rd(4'hB, v);
    rc(4'hB, v);
    wr(4'h2, 32'h21);
    wr(4'h3, 32'h200);
    rd(4'hB, v);
    chk(v >= 32'h1FF && v <= 32'h200, 1);
    wr(4'h2, 32'h0);
    wr(4'hA, 32'h7);
    rc(4'h7, 32'h0);
    chk(irq, 0);
    // edge count for each edge kind, prescaler left set
    wr(4'h1, 32'h3);
    wr(4'h4, 32'h6);
    foreach (evs[i]) begin
      wr(4'h3, 32'hA);
      wr(4'hA, 32'h7);
      wr(4'h2, {evs[i], 2'b01});
      u_pin.toggle(5);
      rc(4'hB, cnt[i]);
      rc(4'h7, {mt[i], 1'b0});
      rc(4'h2, {evs[i], 1'b0, ~mt[i]});
      wr(4'h2, 32'h0);
      u_pin.toggle(1);
    end
    // edge time, rising only
    wr(4'h1, 32'h7);
    wr(4'h3, 32'hFFFF);
    wr(4'hA, 32'h7);
    wr(4'h2, 32'h1);
    rd(4'hB, v);
    rc(4'hB, v - 2);
    u_pin.toggle(1);
    rd(4'h6, v);
    chk(v < 32'hFFFF && v > 32'hFF00, 1);
    rc(4'h7, 32'h4);
    u_pin.toggle(1);
    rc(4'h6, v);
    // pwm, plain then inverted
    wr(4'h2, 32'h0);
    wr(4'hA, 32'h7);
    wr(4'h1, 32'hA);
    wr(4'h3, 32'h10);
    wr(4'h4, 32'h8);
    wr(4'h2, 32'h1);
    duty(hi);
    chk(hi >= 70 && hi <= 95, 1);
    wr(4'h2, 32'h41);
    duty(hi);
    chk(hi >= 85 && hi <= 110, 1);
    rc(4'h7, 32'h0);
    tally_and_finish();
  end
endmodule
